// >>> core/pulse_counter_pkg.sv
// Purpose: Constants and types for the pulse counter channel control block
// Assumes: One clock domain, registers reached over Avalon-MM
// Notes:   Offsets are byte addresses of aligned 32-bit words
package pulse_counter_pkg;

    localparam int CNT_W  = 32;
    localparam int ADDR_W = 4;
    localparam int CH_W   = 2;

    localparam logic [ADDR_W-1:0] OFF_CTRL   = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_COUNT  = 4'h8;
    localparam logic [ADDR_W-1:0] OFF_IRQ_ST = 4'hC;
    // Mask sits in the upper half of the event word
    localparam int IRQ_MASK_POS = 16;

    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_DIR_BIT  = 1;
    localparam int CTRL_EDGE_BIT = 2;
    localparam int CTRL_MODE_POS = 4;
    localparam int CTRL_CH_POS   = 8;

    localparam int ST_BUSY_BIT  = 0;
    localparam int ST_VALID_BIT = 1;
    localparam int ST_FAULT_BIT = 2;
    localparam int ST_CODE_POS  = 8;

    localparam int EV_START_BIT = 0;
    localparam int EV_FAULT_BIT = 1;
    localparam int EV_WRAP_BIT  = 2;
    localparam int EV_W         = 3;

    localparam logic [31:0] READ_ZERO = 32'h0000_0000;
    localparam logic [CNT_W-1:0] COUNT_RST = 32'h0000_0000;
    localparam logic [CNT_W-1:0] COUNT_ONE = 32'h0000_0001;

    typedef enum logic [1:0] {
        updown_mode                = 2'h0,
        updown_reset_mode          = 2'h1,
        updown_reset_enable_mode   = 2'h2,
        updown_reset_enable_mode_b = 2'h3
    } count_mode_e;

    typedef enum logic [3:0] {
        no_fault_code   = 4'h0,
        fault_bad_chan  = 4'h1,
        fault_bad_mode  = 4'h2
    } io_fault_enum_e;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ARM   = 2'b01,
        ST_RUN   = 2'b11,
        ST_FAULT = 2'b10
    } chan_state_e;

    typedef struct packed {
        logic           busy;
        logic           valid;
        logic           fault;
        io_fault_enum_e code;
    } chan_status_s;

endpackage

// >>> core/pulse_counter_block.sv
// Purpose: Control and counting for one high-speed pulse counter channel
// Assumes: Inputs synchronous to CLK; Avalon-MM slave, one wait state
// Notes:   Channel input edges detected per clock against the last sample
`timescale 1ns/10ps
module pulse_counter_block
    import pulse_counter_pkg::*;
#(
    parameter int NUM_CH = 4
)
(
    input  wire logic                 CLK,
    input  wire logic                 RST,
    input  wire logic [ADDR_W-1:0]    AVS_ADDRESS,
    input  wire logic                 AVS_READ,
    input  wire logic                 AVS_WRITE,
    input  wire logic [31:0]          AVS_WRITEDATA,
    input  wire logic [3:0]           AVS_BYTEENABLE,
    output logic      [31:0]          AVS_READDATA,
    output logic                      AVS_WAITREQUEST,
    input  wire logic [NUM_CH-1:0]    DIGITAL_INPUT,
    output logic                      IRQ
);

    ////////////////////////////////////////////////////////////////////////
    logic                  count_enable_r;
    logic                  dir_cfg_r;
    logic                  edge_cfg_r;
    count_mode_e           mode_cfg_r;
    logic [CH_W-1:0]       chan_cfg_r;
    logic                  count_direction_select;
    logic                  edge_polarity_select;
    logic [CH_W-1:0]       counter_channel_handle;
    logic                  en_d_r;
    chan_state_e           state_r;
    chan_status_s          stat_r;
    logic signed [CNT_W-1:0] count_r;
    logic signed [CNT_W-1:0] present_count_r;
    logic [NUM_CH-1:0]     in_d_r;
    logic [EV_W-1:0]       irq_st_r;
    logic [EV_W-1:0]       irq_mask_r;
    logic [EV_W-1:0]       ev;
    logic                  ack_r;
    logic                  en_rise;
    logic                  en_fall;
    logic                  bad_chan;
    logic                  pulse;
    logic                  cur_in;
    logic                  prev_in;
    logic                  wrap;
    logic [CNT_W-1:0]      count_nxt;
    logic                  wr_ctrl;
    logic                  wr_irq;

    ////////////////////////////////////////////////////////////////////////
    // Bus slave: one wait state, then answer
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            ack_r <= 1'b0;
        else
            ack_r <= (AVS_READ | AVS_WRITE) & ~ack_r;
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            AVS_WAITREQUEST <= 1'b1;
        else
            AVS_WAITREQUEST <= ~((AVS_READ | AVS_WRITE) & ~ack_r);
    end

    assign wr_ctrl = AVS_WRITE & ack_r & (AVS_ADDRESS == OFF_CTRL);
    assign wr_irq  = AVS_WRITE & ack_r & (AVS_ADDRESS == OFF_IRQ_ST);

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            count_enable_r <= 1'b0;
            dir_cfg_r      <= 1'b0;
            edge_cfg_r     <= 1'b0;
            mode_cfg_r     <= updown_mode;
            chan_cfg_r     <= '0;
        end
        else if (wr_ctrl)
        begin
            if (AVS_BYTEENABLE[0])
            begin
                count_enable_r <= AVS_WRITEDATA[CTRL_EN_BIT];
                dir_cfg_r      <= AVS_WRITEDATA[CTRL_DIR_BIT];
                edge_cfg_r     <= AVS_WRITEDATA[CTRL_EDGE_BIT];
                mode_cfg_r     <= count_mode_e'(AVS_WRITEDATA[CTRL_MODE_POS +: 2]);
            end
            if (AVS_BYTEENABLE[1])
                chan_cfg_r <= AVS_WRITEDATA[CTRL_CH_POS +: CH_W];
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            AVS_READDATA <= READ_ZERO;
        else if (AVS_READ & ~ack_r)
        begin
            case (AVS_ADDRESS)
                OFF_CTRL:   AVS_READDATA <= {22'h0, chan_cfg_r, 2'h0, mode_cfg_r,
                                             1'b0, edge_cfg_r, dir_cfg_r, count_enable_r};
                OFF_STATUS: AVS_READDATA <= {20'h0, stat_r.code, 5'h0, stat_r.fault,
                                             stat_r.valid, stat_r.busy};
                OFF_COUNT:  AVS_READDATA <= present_count_r;
                OFF_IRQ_ST: AVS_READDATA <= {13'h0, irq_mask_r, 13'h0, irq_st_r};
                default:    AVS_READDATA <= READ_ZERO;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Enable edges and latched settings
    assign en_rise = count_enable_r & ~en_d_r;
    assign en_fall = ~count_enable_r & en_d_r;

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            en_d_r <= 1'b0;
        else
            en_d_r <= count_enable_r;
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            count_direction_select <= 1'b0;
            edge_polarity_select   <= 1'b0;
            counter_channel_handle <= '0;
        end
        else if (en_rise & ~stat_r.busy)
        begin
            count_direction_select <= dir_cfg_r;
            edge_polarity_select   <= edge_cfg_r;
            // Out of range channel never indexes the inputs
            if (!bad_chan)
                counter_channel_handle <= chan_cfg_r;
        end
    end

    assign bad_chan = (32'(chan_cfg_r) >= NUM_CH);

    ////////////////////////////////////////////////////////////////////////
    // Channel state and status flags
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            state_r <= ST_IDLE;
        else
        begin
            case (state_r)
                ST_IDLE:  if (en_rise) state_r <= bad_chan ? ST_FAULT : ST_ARM;
                ST_ARM:   state_r <= count_enable_r ? ST_RUN : ST_IDLE;
                ST_RUN:   if (!count_enable_r) state_r <= ST_IDLE;
                ST_FAULT: if (en_fall) state_r <= ST_IDLE;
                default:  state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            stat_r <= '{busy: 1'b0, valid: 1'b0, fault: 1'b0, code: no_fault_code};
        else
        begin
            // busy on rise, off on stop
            stat_r.busy <= (state_r == ST_IDLE) ? (en_rise & ~bad_chan)
                         : (state_r != ST_FAULT) & count_enable_r;
            stat_r.valid <= ((state_r == ST_ARM) | (state_r == ST_RUN)) & count_enable_r;
            if (state_r == ST_IDLE && en_rise && bad_chan)
            begin
                stat_r.fault <= 1'b1;
                stat_r.code  <= fault_bad_chan;
            end
            else if (en_fall)
            begin
                stat_r.fault <= 1'b0;
                stat_r.code  <= no_fault_code;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counting
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            in_d_r <= '0;
        else
            in_d_r <= DIGITAL_INPUT;
    end

    assign cur_in  = DIGITAL_INPUT[counter_channel_handle];
    assign prev_in = in_d_r[counter_channel_handle];
    assign pulse = edge_polarity_select ? (prev_in & ~cur_in) : (~prev_in & cur_in);
    assign count_nxt = count_direction_select ? count_r - COUNT_ONE : count_r + COUNT_ONE;
    assign wrap = count_direction_select ? (count_r == {1'b1, {(CNT_W-1){1'b0}}})
                                         : (count_r == {1'b0, {(CNT_W-1){1'b1}}});

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            count_r <= COUNT_RST;
        else if (stat_r.busy & count_enable_r & (state_r != ST_FAULT) & pulse)
            count_r <= count_nxt;
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            present_count_r <= COUNT_RST;
        else if (stat_r.valid)
            present_count_r <= count_r;
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupts: set beats clear
    assign ev[EV_START_BIT] = en_rise & ~stat_r.busy & ~bad_chan;
    assign ev[EV_FAULT_BIT] = (state_r == ST_IDLE) & en_rise & bad_chan;
    assign ev[EV_WRAP_BIT]  = stat_r.busy & count_enable_r & pulse & wrap;

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            irq_st_r   <= '0;
            irq_mask_r <= '0;
        end
        else
        begin
            irq_st_r <= ev | (irq_st_r & ~(wr_irq ? AVS_WRITEDATA[EV_W-1:0] : '0));
            if (wr_irq & AVS_BYTEENABLE[2])
                irq_mask_r <= AVS_WRITEDATA[IRQ_MASK_POS +: EV_W];
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            IRQ <= 1'b0;
        else
            IRQ <= |(irq_st_r & irq_mask_r);
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_busy_rise: assert property (@(posedge CLK) disable iff (RST)
        (state_r == ST_IDLE && en_rise && !bad_chan) |=> stat_r.busy)
        else $error("busy did not rise on enable");
    a_busy_drop: assert property (@(posedge CLK) disable iff (RST)
        (!count_enable_r && state_r != ST_IDLE) |=> !stat_r.busy)
        else $error("busy held after enable dropped");
    a_valid_after: assert property (@(posedge CLK) disable iff (RST)
        $rose(stat_r.valid) |-> $past(stat_r.busy))
        else $error("valid rose without prior busy");
    a_fault_clear: assert property (@(posedge CLK) disable iff (RST)
        en_fall |=> (!stat_r.fault && stat_r.code == no_fault_code))
        else $error("fault not cleared on enable fall");
    a_count_track: assert property (@(posedge CLK) disable iff (RST)
        stat_r.valid |=> present_count_r == $past(count_r))
        else $error("present count not following");
    a_count_step: assert property (@(posedge CLK) disable iff (RST)
        (stat_r.busy && count_enable_r && pulse && !count_direction_select)
        |=> count_r == $past(count_r) + 32'sh1)
        else $error("count did not increment");
    a_fault_stop: assert property (@(posedge CLK) disable iff (RST)
        stat_r.fault |=> $stable(count_r))
        else $error("count moved under fault");
    a_cfg_hold: assert property (@(posedge CLK) disable iff (RST)
        (stat_r.busy && !en_rise) |=> $stable(count_direction_select) && $stable(edge_polarity_select))
        else $error("settings changed while counting");
    a_count_down: assert property (@(posedge CLK) disable iff (RST)
        (stat_r.busy && count_enable_r && pulse && count_direction_select)
        |=> count_r == $past(count_r) - 32'sh1)
        else $error("count did not decrement");
    a_fault_idle: assert property (@(posedge CLK) disable iff (RST)
        stat_r.fault |-> (!stat_r.busy && !stat_r.valid))
        else $error("channel active while faulted");
    c_count_up: cover property (@(posedge CLK) disable iff (RST)
        stat_r.valid && pulse && !count_direction_select);
    c_count_dn: cover property (@(posedge CLK) disable iff (RST)
        stat_r.valid && pulse && count_direction_select);
    c_fault: cover property (@(posedge CLK) disable iff (RST) $rose(stat_r.fault));
    c_irq: cover property (@(posedge CLK) disable iff (RST) $rose(IRQ));

endmodule // pulse_counter_block

// >>> test/pulse_source.sv
// Purpose: Pulse source model on the digital inputs of the counter
// Assumes: Lines rest low and change right after a rising clock edge
// Notes:   Each level is held 3 to 5 clocks, so fast and slow sources mix
`timescale 1ns/10ps
module pulse_source
#(
    parameter int N = 3
)
(
    input  wire logic         clk,
    output logic      [N-1:0] lines
);
    initial lines = '0;
    ////////////////////////////////////////////////////////////////////////
    // Drive one line to a level, then hold it
    task automatic step(input int ch, input logic lvl);
        int hold;
        hold = 1 + ($urandom % 3);
        @(posedge clk);
        lines[ch] <= lvl;
        repeat (hold + 1) @(posedge clk);
    endtask
    // Whole pulses on one line
    task automatic pulses(input int ch, input int n);
        repeat (n)
        begin
            step(ch, 1'b1);
            step(ch, 1'b0);
        end
    endtask
endmodule // pulse_source

// >>> test/pulse_counter_block_test.sv
// Purpose: Self-checking bench of the pulse counter channel block
// Assumes: Avalon-MM answers after waitrequest low; NUM_CH set to 3
// Notes:   Channel 3 is out of range and must fault
`timescale 1ns/10ps
module pulse_counter_block_test;
    import pulse_counter_pkg::*;
    localparam int NCH = 3;
    logic              clk;
    logic              rst;
    logic [ADDR_W-1:0] avs_address;
    logic              avs_read;
    logic              avs_write;
    logic [31:0]       avs_writedata;
    logic [31:0]       avs_readdata;
    logic              avs_waitrequest;
    logic [NCH-1:0]    din;
    logic              irq;
    int                miscompares;
    int                check_count;
    pulse_counter_block #(.NUM_CH(NCH)) dut (.CLK(clk), .RST(rst), .AVS_ADDRESS(avs_address),
        .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
        .AVS_BYTEENABLE(4'hF), .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
        .DIGITAL_INPUT(din), .IRQ(irq));
    pulse_source #(.N(NCH)) src (.clk(clk), .lines(din));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected level at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One Avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do
        begin
            @(posedge clk);
        end
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] ctrl(input logic en, input logic dir, input logic edg,
                                         input logic [1:0] md, input logic [1:0] ch);
        logic [31:0] w;
        w = READ_ZERO;
        w[CTRL_EN_BIT] = en;
        w[CTRL_DIR_BIT] = dir;
        w[CTRL_EDGE_BIT] = edg;
        w[CTRL_MODE_POS+:2] = md;
        w[CTRL_CH_POS+:2] = ch;
        return w;
    endfunction
    function automatic logic [31:0] stat(input logic b, input logic v, input logic f, input logic [3:0] c);
        logic [31:0] w;
        w = READ_ZERO;
        w[ST_BUSY_BIT] = b;
        w[ST_VALID_BIT] = v;
        w[ST_FAULT_BIT] = f;
        w[ST_CODE_POS+:4] = c;
        return w;
    endfunction
    function automatic logic [31:0] exp_count(input logic [31:0] base, input int k, input logic dir);
        return dir ? base - k[31:0] : base + k[31:0];
    endfunction
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        tally_and_finish();
    end
    initial
    begin
        logic [31:0] q;
        logic [31:0] base;
        logic [1:0]  ch;
        logic [1:0]  oth;
        logic        dir;
        logic        edg;
        int          n;
        miscompares = 0;
        check_count = 0;
        rst = 1'b1;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        void'($urandom(32'hB31AAF5E));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        bus(0, OFF_STATUS, 0, q); check_word(q, stat(0, 0, 0, no_fault_code));
        bus(0, OFF_COUNT, 0, q); check_word(q, COUNT_RST);
        bus(1, 4'h6, 32'hFFFF_FFFF, q);
        bus(0, 4'h6, 0, q); check_word(q, READ_ZERO);
        for (int i = 0; i < 8; i++)
        begin
            dir = (i < 4) ? ~i[0] : 1'($urandom);
            edg = (i < 4) ? i[1] : 1'($urandom);
            ch = 2'($urandom % NCH);
            oth = 2'((ch + 1) % NCH);
            n = (i == 0) ? 2 : 1 + ($urandom % 6);
            bus(1, OFF_CTRL, ctrl(1, dir, edg, 2'(i), ch), q);
            repeat (4) @(posedge clk);
            bus(0, OFF_STATUS, 0, q); check_word(q, stat(1, 1, 0, no_fault_code));
            bus(0, OFF_COUNT, 0, base);
            bus(1, OFF_CTRL, ctrl(1, ~dir, ~edg, 2'(i), oth), q);
            src.pulses(oth, 2);
            src.pulses(ch, n);
            src.step(ch, 1'b1);
            repeat (3) @(posedge clk);
            bus(0, OFF_COUNT, 0, q); check_word(q, exp_count(base, n + (edg ? 0 : 1), dir));
            src.step(ch, 1'b0);
            bus(1, OFF_CTRL, ctrl(0, dir, edg, 2'(i), ch), q);
            repeat (3) @(posedge clk);
            bus(0, OFF_STATUS, 0, q); check_word(q, stat(0, 0, 0, no_fault_code));
            if (i == 0)
            begin
                check_word(base, COUNT_RST);
                bus(0, OFF_IRQ_ST, 0, q); check_word(q, 32'h0000_0001);
                check_bit(irq, 1'b0);
                bus(1, OFF_IRQ_ST, 32'h0007_0000, q);
                repeat (3) @(posedge clk);
                check_bit(irq, 1'b1);
                bus(1, OFF_IRQ_ST, 32'h0007_0005, q);
                repeat (3) @(posedge clk);
                check_bit(irq, 1'b0);
                bus(0, OFF_IRQ_ST, 0, q); check_word(q, 32'h0007_0000);
            end
        end
        bus(1, OFF_CTRL, ctrl(1, 0, 0, 2'h0, 2'h3), q);
        repeat (4) @(posedge clk);
        bus(0, OFF_STATUS, 0, q); check_word(q, stat(0, 0, 1, fault_bad_chan));
        bus(0, OFF_COUNT, 0, base);
        src.pulses(0, 2);
        bus(0, OFF_COUNT, 0, q); check_word(q, base);
        check_bit(irq, 1'b1);
        bus(0, OFF_IRQ_ST, 0, q); check_word(q, 32'h0007_0003);
        bus(1, OFF_CTRL, READ_ZERO, q);
        repeat (3) @(posedge clk);
        bus(0, OFF_STATUS, 0, q); check_word(q, stat(0, 0, 0, no_fault_code));
        tally_and_finish();
    end
endmodule // pulse_counter_block_test
